// [design/hpbia_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none

module hpbia_arbiter
	import hpbia_pkg::*;
	#(
		parameter int NSLOT  = NUM_SLOTS,
		parameter int SETTLE = SETTLE_CYC
	)
	(
		// clock and pci reset
		input  wire logic              clk,
		input  wire logic              resetn,
		// host bridge idle handshake and bus state pins
		input  wire logic              busIdleGrantN,
		input  wire logic              frameN,
		input  wire logic              irdyN,
		output logic                   busIdleRequestN,
		// cascade to secondary controller
		input  wire logic              cascadeRequestInN,
		output logic                   cascadeGrantOutN,
		// slot connection from sequencing logic
		input  wire logic [NSLOT-1:0]  slotTarget,
		output logic      [NSLOT-1:0]  slotConnect,
		output logic      [NSLOT-1:0]  slotResetN,
		// bus speed indicator, open drain
		input  wire logic [NSLOT-1:0]  slot66Capable,
		output logic                   busSpeedOut,
		output logic                   busSpeedOe,
		// register port select pin
		input  wire logic              controlPortSelect,
		output logic                   serialPortEn,
		output logic                   parallelPortEn,
		// event status and system interrupt, open drain
		input  wire logic [NUM_EVENTS-1:0] eventEnable,
		input  wire logic [NUM_EVENTS-1:0] eventClear,
		output logic      [NUM_EVENTS-1:0] eventStatus,
		output logic                   systemInterruptOut,
		output logic                   systemInterruptOe
	);

	localparam int CW = $clog2(SETTLE + 1);

	// synchronised pins
	logic             grantS;
	logic             frameS;
	logic             irdyS;
	logic             cascReqS;
	logic             selS;
	logic [NSLOT-1:0] m66S;

	// select resets low so the parallel port is not briefly left for serial
	hpbia_sync #(.W(5), .RSTVAL(5'h1E)) u_syncCtl
	(
		.clk    (clk),
		.resetn (resetn),
		.din    ({busIdleGrantN, frameN, irdyN, cascadeRequestInN,
			controlPortSelect}),
		.dout   ({grantS, frameS, irdyS, cascReqS, selS})
	);

	hpbia_sync #(.W(NSLOT), .RSTVAL(SLOTS_ALL_ON)) u_syncM66
	(
		.clk    (clk),
		.resetn (resetn),
		.din    (slot66Capable),
		.dout   (m66S)
	);

	hpbia_state_type  state_r;
	logic [CW-1:0]    settle_r;
	logic             busIdleRequestN_r;
	logic             cascadeGrantOutN_r;
	logic [NSLOT-1:0] slotConnect_r;
	logic [NSLOT-1:0] slotResetN_r;
	logic             busSpeedOut_r;
	logic             busSpeedOe_r;
	logic [1:0]       speedWait_r;
	logic             speedLatched_r;
	logic             serialPortEn_r;
	logic             parallelPortEn_r;
	logic [NUM_EVENTS-1:0] eventStatus_r;
	logic [NUM_EVENTS-1:0] eventSet;
	logic             sysIntOut_r;
	logic             sysIntOe_r;

	logic busIdle;
	logic intPending;
	logic slotChange;

	assign busIdle    = !grantS && frameS && irdyS;
	assign slotChange = slotTarget != slotConnect_r;

	// idle handshake sequencer; the clock also drives the speed, port select, event and interrupt logic
	always_ff @(posedge clk) // [R13]
	begin
		if (!resetn)
		begin
			state_r            <= ST_IDLE;
			settle_r           <= '0;
			busIdleRequestN_r  <= 1'b1;
			cascadeGrantOutN_r <= 1'b1;
		end
		else
		begin
			case (state_r)
			ST_IDLE:
			begin
				// high cascade request means no secondary waiting
				if (!cascReqS || slotChange) // [R7]
				begin
					busIdleRequestN_r <= 1'b0; // [R1] [R5] [R2]
					state_r           <= ST_REQ;
				end
			end
			ST_REQ:
			begin
				// grant counted only while our request stands
				if (!grantS) // [R3]
				begin
					if (!cascReqS)
					begin
						cascadeGrantOutN_r <= 1'b0; // [R6]
						state_r            <= ST_CASCADE;
					end
					else
						state_r <= ST_CHECK;
				end
			end
			ST_CHECK:
			begin
				if (grantS)
					state_r <= ST_REQ;
				else if (busIdle) // [R4]
				begin
					settle_r <= CW'(SETTLE - 1);
					state_r  <= ST_CONNECT;
				end
			end
			ST_CONNECT:
			begin
				if (settle_r == '0)
				begin
					busIdleRequestN_r <= 1'b1; // [R16]
					state_r           <= ST_IDLE;
				end
				else
					settle_r <= settle_r - CW'(1);
			end
			ST_CASCADE:
			begin
				// secondary drops its request when done
				if (cascReqS) // [R7]
				begin
					cascadeGrantOutN_r <= 1'b1;
					busIdleRequestN_r  <= 1'b1; // [R2]
					state_r            <= ST_IDLE;
				end
			end
			default:
			begin
				state_r            <= ST_IDLE;
				busIdleRequestN_r  <= 1'b1;
				cascadeGrantOutN_r <= 1'b1;
			end
			endcase
		end
	end

	// slot connection, all connected after reset
	always_ff @(posedge clk)
	begin
		if (!resetn)
			slotConnect_r <= SLOTS_ALL_ON; // [R8]
		else if (state_r == ST_CHECK && busIdle)
			slotConnect_r <= slotTarget; // [R4]
	end

	// slot resets follow host reset
	always_ff @(posedge clk)
	begin
		if (!resetn)
			slotResetN_r <= SLOTS_IN_RESET; // [R9]
		else
			slotResetN_r <= SLOTS_ALL_ON;
	end

	// speed indicator sampled once after reset, then frozen
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			speedWait_r    <= '0;
			speedLatched_r <= 1'b0;
			busSpeedOut_r  <= 1'b0;
			busSpeedOe_r   <= 1'b0;
		end
		else if (!speedLatched_r)
		begin
			if (speedWait_r == 2'(SPEED_WAIT_CYC - 1))
			begin
				speedLatched_r <= 1'b1;
				// pull m66 low if any slot cannot run at 66
				busSpeedOe_r   <= !(&m66S); // [R11] [R12]
			end
			else
				speedWait_r <= speedWait_r + 2'h1;
		end
	end

	// register port selection
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			serialPortEn_r   <= 1'b0;
			parallelPortEn_r <= 1'b1;
		end
		else
		begin
			serialPortEn_r   <= selS; // [R10]
			parallelPortEn_r <= !selS;
		end
	end

	assign eventSet[EV_CONNECT_DONE] = state_r == ST_CONNECT
		&& settle_r == '0;
	assign eventSet[EV_CASCADE_DONE] = state_r == ST_CASCADE && cascReqS;
	assign intPending = |(eventStatus_r & eventEnable);

	// sticky status, set beats clear
	always_ff @(posedge clk)
	begin
		if (!resetn)
			eventStatus_r <= EVENTS_CLEAR;
		else
			eventStatus_r <= (eventStatus_r & ~eventClear)
				| eventSet; // [R14]
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sysIntOut_r <= 1'b0;
			sysIntOe_r  <= 1'b0;
		end
		else
		begin
			sysIntOut_r <= 1'b0;
			sysIntOe_r  <= intPending; // [R15]
		end
	end

	assign busIdleRequestN    = busIdleRequestN_r;
	assign cascadeGrantOutN   = cascadeGrantOutN_r;
	assign slotConnect        = slotConnect_r;
	assign slotResetN         = slotResetN_r;
	assign busSpeedOut        = busSpeedOut_r;
	assign busSpeedOe         = busSpeedOe_r;
	assign serialPortEn       = serialPortEn_r;
	assign parallelPortEn     = parallelPortEn_r;
	assign eventStatus        = eventStatus_r;
	assign systemInterruptOut = sysIntOut_r;
	assign systemInterruptOe  = sysIntOe_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence idleSeen;
		state_r == ST_CHECK && busIdle;
	endsequence

	sequence connectHold;
		(state_r == ST_CONNECT && !busIdleRequestN_r) [*4]
		##1 (state_r == ST_IDLE && busIdleRequestN_r);
	endsequence

	connect_after_idle_a: assert property // [R4]
		($changed(slotConnect_r)
			|-> $past(state_r) == ST_CHECK && $past(busIdle))
		else $error("slot connection changed without idle bus");

	request_held_a: assert property // [R16]
		(idleSeen |=> connectHold)
		else $error("idle request not held through connection");

	cascade_request_a: assert property // [R5]
		(state_r == ST_IDLE && !cascReqS |=> !busIdleRequestN_r)
		else $error("cascade request not forwarded");

	cascade_grant_a: assert property // [R6]
		($fell(cascadeGrantOutN_r)
			|-> !$past(grantS) && !$past(busIdleRequestN_r))
		else $error("cascade grant without host grant");

	no_cascade_high_a: assert property // [R7]
		(state_r == ST_IDLE && cascReqS && !slotChange
			|=> busIdleRequestN_r)
		else $error("request raised with nothing pending");

	slot_reset_a: assert property // [R9]
		(slotResetN_r == SLOTS_ALL_ON |-> $past(resetn))
		else $error("slot reset released during host reset");

	port_select_a: assert property // [R10]
		(serialPortEn_r == $past(selS) && parallelPortEn_r != serialPortEn_r)
		else $error("register port select wrong");

	speed_frozen_a: assert property // [R12]
		(speedLatched_r && $past(speedLatched_r) |-> $stable(busSpeedOe_r))
		else $error("speed indicator changed in operation");

	interrupt_drive_a: assert property // [R15]
		(sysIntOe_r == $past(intPending)
			&& !sysIntOut_r)
		else $error("interrupt open drain drive wrong");

	event_sticky_a: assert property // [R14]
		(eventSet[EV_CONNECT_DONE] |=> eventStatus_r[EV_CONNECT_DONE])
		else $error("connect event lost");

endmodule

`default_nettype wire

// [design/hpbia_pkg.sv]
// Function
// (R1) Request bus idle from host bridge before any slot connection change.
// (R2) Idle request and grant are active low, handled like PCI request/grant.
// (R3) Host bridge grants idle only after the device has raised its request.
// (R4) Connect only after grant low and frame and initiator-ready seen high.
// (R5) A low cascade request makes this device request bus idle for it.
// (R6) Grant from the host is passed on as the cascade grant output.
// (R7) High cascade request means nothing pending; no secondary is present.
// (R8) Reset leaves every slot enabled and connected, like a plain system.
// (R9) Host reset is forwarded to every controlled slot.
// (R10) Select high gives serial register access, low gives parallel access.
// (R11) Bus-speed indicator shows the slots' clock needs on the M66EN line.
// (R12) Bus-speed indicator changes only after a reset, never in operation.
// (R13) The clock serves only blink timing, idle handshake and connection; here it also clocks speed latch, port select, events and interrupt.
// (R14) Interrupt asserts from sticky event status gated by enable bits.
// (R15) Interrupt line is open drain: pulled low when active, else released.
// (R16) Idle request stays asserted until connection step ends, then drops.
`default_nettype none

package hpbia_pkg;

	localparam int NUM_SLOTS     = 4;
	localparam int NUM_EVENTS    = 2;

	// clock and connection settle time
	localparam int CLK_PERIOD_NS = 25;
	localparam int SETTLE_NS     = 100;
	localparam int SETTLE_CYC    =
		(SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SPEED_WAIT_CYC = 3;

	// event status bit positions
	localparam int EV_CONNECT_DONE = 0;
	localparam int EV_CASCADE_DONE = 1;

	// reset values
	localparam logic [NUM_SLOTS-1:0]  SLOTS_ALL_ON   = 4'hF;
	localparam logic [NUM_SLOTS-1:0]  SLOTS_IN_RESET = 4'h0;
	localparam logic [NUM_EVENTS-1:0] EVENTS_CLEAR   = 2'h0;

	typedef enum logic [4:0]
	{
		ST_IDLE    = 5'h01,
		ST_REQ     = 5'h02,
		ST_CHECK   = 5'h04,
		ST_CONNECT = 5'h08,
		ST_CASCADE = 5'h10
	} hpbia_state_type;

endpackage

`default_nettype wire

// [design/hpbia_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module hpbia_sync
	#(
		parameter int         W      = 1,
		parameter logic [W-1:0] RSTVAL = '0
	)
	(
		// clock and reset
		input  wire logic         clk,
		input  wire logic         resetn,
		// data
		input  wire logic [W-1:0] din,
		output logic      [W-1:0] dout
	);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			meta_r <= RSTVAL;
			dout   <= RSTVAL;
		end
		else
		begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule

`default_nettype wire

// [verification/hpbia_arbiter_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module hpbia_arbiter_bench import hpbia_pkg::*;;

	logic       clk, resetn, grantN, frameN, irdyN, reqN, casReqN, casGntN;
	logic       spdOut, spdOe, serEn, parEn, intOut, intOe, portSel, slow;
	logic [3:0] tgt, conn, slotRstN, cap66;
	logic [1:0] evEn, evClr, evSt;
	int         fails, checks;
	// target in the high nibble, expected connection in the low nibble
	logic [7:0] rows [4] = '{8'h00, 8'h55, 8'hAA, 8'h33};

	hpbia_host_model u_hpbia_host_model (.clk(clk), .resetn(resetn),
		.reqN(reqN), .slow(slow), .grantN(grantN));

	hpbia_arbiter u_hpbia_arbiter (.clk(clk), .resetn(resetn),
		.busIdleGrantN(grantN), .frameN(frameN), .irdyN(irdyN),
		.busIdleRequestN(reqN), .cascadeRequestInN(casReqN),
		.cascadeGrantOutN(casGntN), .slotTarget(tgt), .slotConnect(conn),
		.slotResetN(slotRstN), .slot66Capable(cap66), .busSpeedOut(spdOut),
		.busSpeedOe(spdOe), .controlPortSelect(portSel),
		.serialPortEn(serEn), .parallelPortEn(parEn), .eventEnable(evEn),
		.eventClear(evClr), .eventStatus(evSt),
		.systemInterruptOut(intOut), .systemInterruptOe(intOe));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic waitFor(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 60)
		begin
			@(posedge clk);
			#2;
			n++;
		end
		chk("handshake wait", {7'h0, s}, {7'h0, v});
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task wrap_up();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		#100000;
		fails++;
		wrap_up();
	end

	initial
	begin
		{resetn, evEn, evClr, portSel, slow} = '0;
		{frameN, irdyN, casReqN} = 3'h7;
		tgt   = 4'hF;
		cap66 = 4'hF;
		cyc(2);
		chk("conn", {4'h0, conn}, 8'h0F);
		chk("slotRst", {4'h0, slotRstN}, 8'h00);
		chk("req", {7'h0, reqN}, 8'h01);
		chk("ports", {6'h0, serEn, parEn}, 8'h01);
		resetn = 1'b1;
		cyc(1);
		chk("slotRst", {4'h0, slotRstN}, 8'h0F);
		cyc(4);
		chk("speed", {6'h0, spdOut, spdOe}, 8'h00);
		cap66 = 4'h0;
		cyc(6);
		chk("speed", {7'h0, spdOe}, 8'h00);
		evEn = 2'h1;
		foreach (rows[i])
		begin
			tgt = rows[i][7:4];
			waitFor(reqN, 1'b0);
			waitFor(reqN, 1'b1);
			chk("conn", {4'h0, conn}, {4'h0, rows[i][3:0]});
			cyc(2);
			chk("event", {6'h0, evSt}, 8'h01);
			chk("system_interrupt", {6'h0, intOut, intOe}, 8'h01);
			evClr = 2'h1;
			cyc(1);
			evClr = 2'h0;
			cyc(2);
			chk("system_interrupt", {7'h0, intOe}, 8'h00);
		end
		// bus stays busy past a slow grant
		slow   = 1'b1;
		frameN = 1'b0;
		irdyN  = 1'b0;
		tgt    = 4'hC;
		waitFor(reqN, 1'b0);
		cyc(20);
		chk("conn", {4'h0, conn}, 8'h03);
		chk("req", {7'h0, reqN}, 8'h00);
		frameN = 1'b1;
		cyc(5);
		chk("conn", {4'h0, conn}, 8'h03);
		irdyN = 1'b1;
		waitFor(reqN, 1'b1);
		chk("conn", {4'h0, conn}, 8'h0C);
		evClr = 2'h1;
		cyc(1);
		evClr = 2'h0;
		slow  = 1'b0;
		// cascaded secondary request, event masked
		cyc(3);
		chk("casGnt", {7'h0, casGntN}, 8'h01);
		casReqN = 1'b0;
		waitFor(casGntN, 1'b0);
		chk("req", {7'h0, reqN}, 8'h00);
		casReqN = 1'b1;
		waitFor(casGntN, 1'b1);
		chk("req", {7'h0, reqN}, 8'h01);
		cyc(2);
		chk("event", {6'h0, evSt}, 8'h02);
		chk("system_interrupt", {7'h0, intOe}, 8'h00);
		portSel = 1'b1;
		cyc(4);
		chk("ports", {6'h0, serEn, parEn}, 8'h02);
		cap66  = 4'h7;
		resetn = 1'b0;
		cyc(2);
		chk("speed", {7'h0, spdOe}, 8'h00);
		resetn = 1'b1;
		cyc(5);
		chk("speed", {6'h0, spdOut, spdOe}, 8'h01);
		wrap_up();
	end

endmodule

`default_nettype wire

// [verification/hpbia_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module hpbia_host_model
	(
		// clock and reset
		input  wire logic clk,
		input  wire logic resetn,
		// idle handshake
		input  wire logic reqN,
		input  wire logic slow,
		output logic      grantN
	);

	logic [3:0] cnt_r;

	// grant only while a request stands, after a short or long delay
	always_ff @(posedge clk)
	begin
		if (!resetn || reqN)
		begin
			grantN <= 1'b1;
			cnt_r  <= 4'h0;
		end
		else if (cnt_r < (slow ? 4'h9 : 4'h1))
			cnt_r <= cnt_r + 4'h1;
		else
			grantN <= 1'b0;
	end

endmodule

`default_nettype wire
